// File: fbo_cfg.svh
// Register offsets, field positions, reset values and timing counts of the flash bus host.
`ifndef FBO_CFG_SVH
`define FBO_CFG_SVH

`define FBO_OFS_ADDR 8'h00
`define FBO_OFS_WDATA 8'h04
`define FBO_OFS_CMD 8'h08
`define FBO_OFS_CFG 8'h0C
`define FBO_OFS_STATUS 8'h10
`define FBO_OFS_RDATA 8'h14

`define FBO_CMD_READ 0
`define FBO_CMD_WRITE 1
`define FBO_CMD_RESET 2
`define FBO_CFG_BYTE 0
`define FBO_ST_BUSY 0
`define FBO_ST_RDY 1
`define FBO_ST_DONE 2
`define FBO_ST_BYTE 3

`define FBO_CFG_RESET 1'b0

`define FBO_CLK_NS 100
`define FBO_CHIP_SELECT_ACCESS_TIME_NS 120
`define FBO_WE_PULSE_NS 100
`define FBO_RESET_PULSE_MIN_NS 500
`define FBO_RESET_RECOVERY_TIME_NS 50
`define FBO_CYC_UP(ns) (((ns) + `FBO_CLK_NS - 1) / `FBO_CLK_NS)
`define FBO_ACC_CYC `FBO_CYC_UP(`FBO_CHIP_SELECT_ACCESS_TIME_NS)
`define FBO_WE_CYC `FBO_CYC_UP(`FBO_WE_PULSE_NS)
`define FBO_RP_CYC `FBO_CYC_UP(`FBO_RESET_PULSE_MIN_NS)
`define FBO_RH_CYC `FBO_CYC_UP(`FBO_RESET_RECOVERY_TIME_NS)

`endif

// File: fbo_pkg.sv
// Types shared by the flash bus host.
package fbo_pkg;
    typedef enum logic [2:0] {
        FBO_IDLE = 3'b000,
        FBO_RD = 3'b001,
        FBO_WR = 3'b010,
        FBO_WREC = 3'b011,
        FBO_RST = 3'b100,
        FBO_RREC = 3'b101
    } fbo_state_t;

    typedef struct packed {
        logic ce_n;
        logic oe_n;
        logic we_n;
        logic rst_n;
        logic byte_n;
        logic [17:0] addr;
    } fbo_pins_t;
endpackage : fbo_pkg

// File: fbo_host.sv
// AHB-Lite controlled host that drives an asynchronous parallel flash through its pins.
`timescale 1ns/1ps
`default_nettype none
`include "fbo_cfg.svh"

module fbo_host #(
    parameter int ACC_CYC = `FBO_ACC_CYC,
    parameter int WE_CYC = `FBO_WE_CYC,
    parameter int RP_CYC = `FBO_RP_CYC,
    parameter int RH_CYC = `FBO_RH_CYC
) (
    input wire logic sys_clk_in, // System clock, 10 MHz.
    input wire logic rstn_in, // Synchronous reset, active low.
    input wire logic hsel_in, // AHB slave select.
    input wire logic [31:0] haddr_in, // AHB address.
    input wire logic [1:0] htrans_in, // AHB transfer type.
    input wire logic hwrite_in, // AHB write flag.
    input wire logic [2:0] hsize_in, // AHB transfer size.
    input wire logic hready_in, // AHB bus ready.
    input wire logic [31:0] hwdata_in, // AHB write data.
    output logic [31:0] hrdata_out, // AHB read data.
    output logic hreadyout_out, // AHB slave ready.
    output logic hresp_out, // AHB response, always OKAY.
    output var fbo_pkg::fbo_pins_t pins_out, // Flash control and address pins.
    input wire logic [15:0] dq_in, // Flash data pins as seen on the wire.
    output logic [15:0] dq_out, // Flash data pins, driven value.
    output logic [15:0] dq_oe_n_out, // Flash data pin enables, low drives.
    input wire logic ready_busy_n_in // Flash ready_busy_n pin.
);
    import fbo_pkg::*;

    fbo_state_t st;
    fbo_state_t next_st;
    logic [15:0] tmr;
    logic [15:0] next_tmr;
    logic [18:0] addr_reg;
    logic [15:0] wdata_reg;
    logic [15:0] rdata_reg;
    logic byte_mode;
    logic done;
    logic ap_wr;
    logic [7:0] ap_addr;
    logic [15:0] dq_drv;

    function automatic logic [15:0] cyc16(input int n);
        cyc16 = 16'(n - 1);
    endfunction : cyc16

    // Bus slave: zero wait states, registered address phase.
    wire ap_take = hsel_in && hready_in && htrans_in[1];
    wire wr_addr = ap_wr && (ap_addr == `FBO_OFS_ADDR);
    wire wr_wdata = ap_wr && (ap_addr == `FBO_OFS_WDATA);
    wire wr_cmd = ap_wr && (ap_addr == `FBO_OFS_CMD);
    wire wr_cfg = ap_wr && (ap_addr == `FBO_OFS_CFG);
    wire wr_stat = ap_wr && (ap_addr == `FBO_OFS_STATUS);
    wire idle = (st == FBO_IDLE);
    wire go_rst = wr_cmd && hwdata_in[`FBO_CMD_RESET];
    wire go_rd = wr_cmd && idle && !go_rst && hwdata_in[`FBO_CMD_READ];
    wire go_wr = wr_cmd && idle && !go_rst && !go_rd && hwdata_in[`FBO_CMD_WRITE];
    wire tmr_end = (tmr == 16'h0000);
    wire rd_cap = (st == FBO_RD) && tmr_end;

    wire [31:0] status_word = {28'h0000000, byte_mode, done, ready_busy_n_in, !idle};
    wire [7:0] ra = haddr_in[7:0];
    wire [31:0] rd_word =
        (ra == `FBO_OFS_ADDR) ? {13'h0000, addr_reg} :
        (ra == `FBO_OFS_WDATA) ? {16'h0000, wdata_reg} :
        (ra == `FBO_OFS_CFG) ? {31'h00000000, byte_mode} :
        (ra == `FBO_OFS_STATUS) ? status_word :
        (ra == `FBO_OFS_RDATA) ? {16'h0000, rdata_reg} : 32'h00000000;

    assign hreadyout_out = 1'b1;
    assign hresp_out = 1'b0;

    always_ff @(posedge sys_clk_in) begin
        if (!rstn_in) begin
            ap_wr <= 1'b0;
            ap_addr <= 8'h00;
            hrdata_out <= 32'h00000000;
        end else begin
            ap_wr <= ap_take && hwrite_in;
            ap_addr <= haddr_in[7:0];
            if (ap_take && !hwrite_in) begin
                hrdata_out <= rd_word;
            end
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (!rstn_in) begin
            addr_reg <= 19'h00000;
            wdata_reg <= 16'h0000;
            byte_mode <= `FBO_CFG_RESET;
        end else begin
            // Address and width only change while idle so a cycle never sees them move.
            if (wr_addr && idle) begin
                addr_reg <= hwdata_in[18:0];
            end
            if (wr_wdata && idle) begin
                wdata_reg <= hwdata_in[15:0];
            end
            if (wr_cfg && idle) begin
                byte_mode <= hwdata_in[`FBO_CFG_BYTE];
            end
        end
    end

    // Completion flag: a finishing cycle wins over a software clear in the same cycle.
    wire op_end = rd_cap || ((st == FBO_WREC) && tmr_end) || ((st == FBO_RREC) && tmr_end);
    always_ff @(posedge sys_clk_in) begin
        if (!rstn_in) begin
            done <= 1'b0;
            rdata_reg <= 16'h0000;
        end else begin
            if (op_end) begin
                done <= 1'b1;
            end else if (wr_stat && hwdata_in[`FBO_ST_DONE]) begin
                done <= 1'b0;
            end
            if (rd_cap) begin
                rdata_reg <= byte_mode ? {8'h00, dq_in[7:0]} : dq_in;
            end
        end
    end

    // Sequencer for read, write and reset cycles.
    always_comb begin
        next_st = st;
        next_tmr = tmr_end ? 16'h0000 : tmr - 16'h0001;
        case (st)
            FBO_IDLE: begin
                if (go_rst) begin
                    next_st = FBO_RST;
                    next_tmr = cyc16(RP_CYC);
                end else if (go_rd) begin
                    next_st = FBO_RD;
                    next_tmr = cyc16(ACC_CYC);
                end else if (go_wr) begin
                    next_st = FBO_WR;
                    next_tmr = cyc16(WE_CYC);
                end
            end
            FBO_RD: begin
                if (tmr_end) begin
                    next_st = FBO_IDLE;
                end
            end
            FBO_WR: begin
                if (tmr_end) begin
                    next_st = FBO_WREC;
                    next_tmr = 16'h0000;
                end
            end
            FBO_WREC: begin
                if (tmr_end) begin
                    next_st = FBO_IDLE;
                end
            end
            FBO_RST: begin
                if (tmr_end) begin
                    next_st = FBO_RREC;
                    next_tmr = cyc16(RH_CYC);
                end
            end
            FBO_RREC: begin
                if (tmr_end) begin
                    next_st = FBO_IDLE;
                end
            end
            default: begin
                next_st = FBO_IDLE;
                next_tmr = 16'h0000;
            end
        endcase
        if (go_rst && !idle) begin
            // A reset request aborts any cycle in progress.
            next_st = FBO_RST;
            next_tmr = cyc16(RP_CYC);
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (!rstn_in) begin
            st <= FBO_IDLE;
            tmr <= 16'h0000;
        end else begin
            st <= next_st;
            tmr <= next_tmr;
        end
    end

    // Pin levels are decoded from the next state and registered, so pins never glitch.
    wire n_access = (next_st == FBO_RD) || (next_st == FBO_WR) || (next_st == FBO_WREC);
    wire n_ce_n = !n_access;
    wire n_oe_n = (next_st != FBO_RD);
    wire n_we_n = (next_st != FBO_WR);
    wire n_rst_n = (next_st != FBO_RST);
    wire n_wdrv = (next_st == FBO_WR) || (next_st == FBO_WREC);
    wire n_top_drv = byte_mode ? 1'b1 : n_wdrv;
    wire n_mid_drv = n_wdrv && !byte_mode;
    wire [15:0] n_dq = byte_mode ? {addr_reg[0], 7'h00, wdata_reg[7:0]} : wdata_reg;
    wire [15:0] n_drv = {n_top_drv, {7{n_mid_drv}}, {8{n_wdrv}}};
    wire [17:0] n_addr = byte_mode ? addr_reg[18:1] : addr_reg[17:0];

    always_ff @(posedge sys_clk_in) begin
        if (!rstn_in) begin
            pins_out <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, rst_n: 1'b1, byte_n: 1'b1, addr: 18'h00000};
            dq_out <= 16'h0000;
            dq_drv <= 16'h0000;
        end else begin
            pins_out <= '{ce_n: n_ce_n, oe_n: n_oe_n, we_n: n_we_n, rst_n: n_rst_n,
                          byte_n: !byte_mode, addr: n_addr};
            dq_out <= n_dq;
            dq_drv <= n_drv;
        end
    end

    assign dq_oe_n_out = ~dq_drv;

    // Helper counters watched only by the checks below.
    logic [7:0] oe_lo_cnt;
    logic [7:0] rst_lo_cnt;
    logic [7:0] since_rst;
    always_ff @(posedge sys_clk_in) begin
        if (!rstn_in) begin
            oe_lo_cnt <= 8'h00;
            rst_lo_cnt <= 8'h00;
            since_rst <= 8'hFF;
        end else begin
            oe_lo_cnt <= pins_out.oe_n ? 8'h00 : (oe_lo_cnt == 8'hFF ? 8'hFF : oe_lo_cnt + 8'h01);
            rst_lo_cnt <= pins_out.rst_n ? 8'h00 : (rst_lo_cnt == 8'hFF ? 8'hFF : rst_lo_cnt + 8'h01);
            since_rst <= !pins_out.rst_n ? 8'h00 : (since_rst == 8'hFF ? 8'hFF : since_rst + 8'h01);
        end
    end

    a_read_we_high: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
        (!pins_out.ce_n && !pins_out.oe_n) |-> pins_out.we_n)
        else $error("Write enable low during a read.");

    a_write_oe_high: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
        !pins_out.we_n |-> (pins_out.oe_n && !pins_out.ce_n && dq_oe_n_out[7:0] == 8'h00))
        else $error("Write strobe without chip select or with output enable.");

    a_no_contention: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
        !pins_out.oe_n |-> (dq_oe_n_out[14:0] == 15'h7FFF))
        else $error("Host drives data pins while the flash outputs.");

    a_byte_top_pin: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
        !pins_out.byte_n |-> (!dq_oe_n_out[15] && dq_oe_n_out[14:8] == 7'h7F))
        else $error("Byte mode pin usage wrong.");

    a_access_wait: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
        rd_cap |-> (!pins_out.ce_n && !pins_out.oe_n && int'(oe_lo_cnt) + 1 >= ACC_CYC))
        else $error("Read data taken before access time.");

    a_reset_width: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
        $rose(pins_out.rst_n) |-> int'($past(rst_lo_cnt)) + 1 >= RP_CYC)
        else $error("Reset pulse shorter than minimum.");

    a_reset_quiet: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
        !pins_out.rst_n |-> (pins_out.ce_n && pins_out.oe_n && pins_out.we_n))
        else $error("Access attempted while flash reset is low.");

    a_reset_recover: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
        $fell(pins_out.ce_n) |-> int'(since_rst) >= RH_CYC)
        else $error("Access started inside reset recovery time.");

    a_done_sets: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
        rd_cap |=> done && (st == FBO_IDLE) && pins_out.ce_n && pins_out.oe_n)
        else $error("Read completion not flagged.");

    c_read: cover property (@(posedge sys_clk_in) disable iff (!rstn_in) rd_cap && pins_out.byte_n);
    c_byte_read: cover property (@(posedge sys_clk_in) disable iff (!rstn_in) rd_cap && !pins_out.byte_n);
    c_write: cover property (@(posedge sys_clk_in) disable iff (!rstn_in) $rose(pins_out.we_n));
    c_reset: cover property (@(posedge sys_clk_in) disable iff (!rstn_in) $rose(pins_out.rst_n));
endmodule : fbo_host
`default_nettype wire

// File: fbo_host_tail_note.sv
// Holds no logic; the whole host lives in its own source file.
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// File: fbo_flash_model.sv
// Behavioural model of the parallel flash device that the host drives.
`timescale 1ns/1ps
`default_nettype none
module fbo_flash_model #(
    parameter logic [7:0] ID_CODE = 8'h5A // Arbitrary identification code.
) (
    input wire fbo_pkg::fbo_pins_t pins_in, // Control and address pins.
    input wire logic [15:0] dq_in, // Resolved data wire.
    output logic [15:0] dq_out, // Driven data value.
    output logic [15:0] dq_oe_n_out, // Data enables, low drives.
    output logic ready_busy_n_out // Low while programming.
);
    import fbo_pkg::*;
    logic [15:0] mem [16];
    logic [15:0] pd;
    logic [3:0] pa;
    logic mode;
    logic ab;
    wire [3:0] a = pins_in.addr[3:0];
    wire rd_en = !pins_in.ce_n && !pins_in.oe_n && pins_in.we_n && pins_in.rst_n;
    wire [15:0] word = !ready_busy_n_out ? {8'h00, ~pd[7], 7'h00} : mode ? {8'h00, ID_CODE} : mem[a];
    wire [15:0] bval = dq_in[15] ? {8'h00, word[15:8]} : {8'h00, word[7:0]};
    assign dq_out = pins_in.byte_n ? word : bval;
    assign dq_oe_n_out = !rd_en ? 16'hFFFF : pins_in.byte_n ? 16'h0000 : 16'hFF00;
    initial begin
        mode = 1'b0;
        ab = 1'b0;
        pd = 16'h0000;
        pa = 4'h0;
        ready_busy_n_out = 1'b1;
        for (int i = 0; i < 16; i++) mem[i] = 16'(i * 16'h1357) ^ 16'hA5C3;
    end
    // Latch on the rising write strobe, when address and data are settled.
    always @(posedge pins_in.we_n) begin
        if (!pins_in.ce_n && pins_in.rst_n && ready_busy_n_out) begin
            if (dq_in == 16'h0090) mode = 1'b1;
            else if (dq_in == 16'h00F0) mode = 1'b0;
            else begin
                pa = a;
                pd = pins_in.byte_n ? dq_in : dq_in[15] ? {dq_in[7:0], mem[a][7:0]} : {mem[a][15:8], dq_in[7:0]};
                ready_busy_n_out = 1'b0;
            end
        end
    end
    // The embedded operation runs on even if chip select goes away.
    // It polls for an abort so that a reset ends it at once and a restart can be taken.
    always @(negedge ready_busy_n_out) begin
        ab = 1'b0;
        for (int t = 0; t < 50 && !ab; t++) #100;
        if (!ab) begin
            mem[pa] = pd;
            ready_busy_n_out = 1'b1;
        end
    end
    always @(negedge pins_in.rst_n) begin
        mode = 1'b0;
        if (!ready_busy_n_out) begin
            ab = 1'b1;
            #300;
            ready_busy_n_out = 1'b1;
        end
    end
endmodule : fbo_flash_model
`default_nettype wire

// File: tb.sv
// Self-checking testbench of the flash bus host against the flash model.
`timescale 1ns/1ps
`default_nettype none
module tb;
    import fbo_pkg::*;
    localparam int RP = 5;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    wire [31:0] hrdata;
    wire hready;
    wire hresp;
    fbo_pins_t pins;
    wire [15:0] h_dq;
    wire [15:0] h_oe;
    wire [15:0] m_dq;
    wire [15:0] m_oe;
    wire [15:0] dq;
    wire rbn;
    logic [15:0] hold = 16'h0;
    logic [15:0] shadow [16];
    logic [31:0] seed = 32'hBE4EA3F4;
    logic [31:0] rv;
    int errors = 0;
    int tests_run = 0;
    int rcnt = 0;
    always #50 clk = ~clk;
    // Undriven bits show a changing pattern, never a stale value.
    assign dq = (~h_oe & h_dq) | (~m_oe & m_dq) | (h_oe & m_oe & ~hold);
    always @(posedge clk) hold <= dq;
    always @(posedge clk) if (!pins.rst_n) rcnt <= rcnt + 1;
    fbo_host #(.ACC_CYC(2), .WE_CYC(1), .RP_CYC(RP), .RH_CYC(1)) fbo_host_inst (.sys_clk_in(clk),
        .rstn_in(rstn), .hsel_in(1'b1), .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite),
        .hsize_in(3'h2), .hready_in(hready), .hwdata_in(hwdata), .hrdata_out(hrdata),
        .hreadyout_out(hready), .hresp_out(hresp), .pins_out(pins), .dq_in(dq), .dq_out(h_dq),
        .dq_oe_n_out(h_oe), .ready_busy_n_in(rbn));
    fbo_flash_model fbo_flash_model_inst (.pins_in(pins), .dq_in(dq), .dq_out(m_dq),
        .dq_oe_n_out(m_oe), .ready_busy_n_out(rbn));
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
        tests_run++;
        if (s !== e) begin
            errors++;
            $display("MISMATCH %s exp %h got %h", n, e, s);
        end
    endtask : chk
    always @(posedge clk) begin
        if (rstn) chk("dq_single_driver", 32'h0, {16'h0, ~h_oe & ~m_oe});
        if (rstn) chk("we_in_read", 32'h0, {31'h0, !pins.ce_n && !pins.oe_n && !pins.we_n});
        if (rstn) chk("hresp_okay", 32'h0, {31'h0, hresp});
    end
    task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= w;
        do @(posedge clk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hready !== 1'b1);
        rv = hrdata;
    endtask : ahb
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        ahb(1'b1, a, d);
    endtask : wr
    task automatic rd(input logic [7:0] a);
        ahb(1'b0, a, 32'h0);
    endtask : rd
    task automatic op(input logic [31:0] c);
        int n;
        wr(8'h08, c);
        n = 0;
        do begin
            rd(8'h10);
            n++;
        end while (rv[0] !== 1'b0 && n < 40);
        chk("done", 32'h1, {31'h0, rv[2]});
        wr(8'h10, 32'h4);
    endtask : op
    task automatic final_report();
        $display("COUNTS tests_run %0d errors %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : final_report
    initial begin
        #3000000;
        errors++;
        final_report();
    end
    initial begin
        logic [17:0] a;
        logic [15:0] d;
        int n;
        for (int i = 0; i < 16; i++) shadow[i] = 16'(i * 16'h1357) ^ 16'hA5C3;
        repeat (3) @(posedge clk);
        rstn <= 1'b1;
        rd(8'h0C);
        chk("cfg_reset", 32'h0, rv);
        rd(8'h10);
        chk("status_reset", 32'h2, rv);
        rd(8'h40);
        chk("unmapped", 32'h0, rv);
        chk("pins_idle", 32'hF, {28'h0, pins.ce_n, pins.oe_n, pins.we_n, pins.rst_n});
        $display("TEST reset done");
        for (int i = 0; i < 4; i++) begin
            seed = lfsr(seed);
            a = seed[17:0];
            wr(8'h00, {14'h0, a});
            op(32'h1);
            rd(8'h14);
            chk("word_read", {16'h0, shadow[a[3:0]]}, rv);
        end
        $display("TEST word read done");
        d = {1'b1, seed[30:16]};
        wr(8'h04, {16'h0, d});
        op(32'h2);
        op(32'h1);
        rd(8'h14);
        chk("busy_status", {24'h0, ~d[7], 7'h0}, rv);
        n = 0;
        do begin
            rd(8'h10);
            n++;
        end while (rv[1] !== 1'b1 && n < 100);
        chk("ready_after_program", 32'h1, {31'h0, rv[1]});
        op(32'h1);
        rd(8'h14);
        chk("programmed", {16'h0, d}, rv);
        shadow[a[3:0]] = d;
        $display("TEST program done");
        wr(8'h04, 32'h90);
        op(32'h2);
        op(32'h1);
        rd(8'h14);
        chk("ident", 32'h5A, rv);
        wr(8'h04, 32'hF0);
        op(32'h2);
        op(32'h1);
        rd(8'h14);
        chk("array_again", {16'h0, shadow[a[3:0]]}, rv);
        $display("TEST mode done");
        wr(8'h0C, 32'h1);
        rd(8'h10);
        chk("byte_flag", 32'h1, {31'h0, rv[3]});
        for (int b = 0; b < 2; b++) begin
            seed = lfsr(seed);
            a = seed[17:0];
            wr(8'h00, {13'h0, a, b[0]});
            op(32'h1);
            rd(8'h14);
            chk("byte_read", {24'h0, b[0] ? shadow[a[3:0]][15:8] : shadow[a[3:0]][7:0]}, rv);
        end
        wr(8'h0C, 32'h0);
        $display("TEST byte done");
        wr(8'h00, {14'h0, a});
        wr(8'h04, 32'h90);
        op(32'h2);
        d = {1'b1, seed[14:0]};
        wr(8'h04, {16'h0, d});
        op(32'h2);
        n = rcnt;
        op(32'h4);
        chk("reset_width", 32'(RP), 32'(rcnt - n));
        rd(8'h10);
        chk("ready_after_reset", 32'h1, {31'h0, rv[1]});
        op(32'h1);
        rd(8'h14);
        chk("aborted_array", {16'h0, shadow[a[3:0]]}, rv);
        // The interrupted program is issued again once the flash takes commands.
        op(32'h2);
        n = 0;
        do begin
            rd(8'h10);
            n++;
        end while (rv[1] !== 1'b1 && n < 100);
        chk("ready_after_restart", 32'h1, {31'h0, rv[1]});
        op(32'h1);
        rd(8'h14);
        chk("restarted", {16'h0, d}, rv);
        $display("TEST reset command done");
        // A bus reset in the middle of a read must leave the pins idle and the flags clear.
        wr(8'h08, 32'h1);
        rstn <= 1'b0;
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        rd(8'h10);
        chk("status_midrun_reset", 32'h2, rv);
        chk("pins_midrun_reset", 32'hF, {28'h0, pins.ce_n, pins.oe_n, pins.we_n, pins.rst_n});
        $display("TEST midrun reset done");
        final_report();
    end
endmodule : tb
`default_nettype wire
